// ### logic/iosd_pkg.sv
/*
  Shared constants for the I/O space decoder: operation codes, address
  windows, register indices, bit masks and the controller register map.
  Assumes an 8-bit core bus and a 32-bit AXI4-Lite control bus.
*/
`default_nettype none
package iosd_pkg;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_IO_PORT_READ = 4'h1,
    OP_IO_PORT_WRITE = 4'h2,
    OP_DATA_FETCH = 4'h3,
    OP_DATA_WRITE = 4'h4,
    OP_SET_IO_BIT = 4'h5,
    OP_CLEAR_IO_BIT = 4'h6,
    OP_SKIP_IF_BIT_SET = 4'h7,
    OP_SKIP_IF_BIT_CLEAR = 4'h8
  } iosd_op_e;

  localparam logic [7:0] IO_LAST = 8'h3F;
  localparam logic [7:0] BIT_IO_LAST = 8'h1F;
  localparam logic [7:0] DATA_IO_OFFSET = 8'h20;
  localparam logic [7:0] DATA_IO_LAST = 8'h5F;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam int IO_SIZE = 64;

  localparam logic [5:0] PORT_B_INPUT_PINS = 6'h03;
  localparam logic [5:0] PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] PORT_C_INPUT_PINS = 6'h06;
  localparam logic [5:0] PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] PORT_C_OUTPUT = 6'h08;
  localparam logic [5:0] PORT_D_INPUT_PINS = 6'h09;
  localparam logic [5:0] PORT_D_DIRECTION = 6'h0A;
  localparam logic [5:0] PORT_D_OUTPUT = 6'h0B;
  localparam logic [5:0] PORT_E_INPUT_PINS = 6'h0C;
  localparam logic [5:0] PORT_E_DIRECTION = 6'h0D;
  localparam logic [5:0] PORT_E_OUTPUT = 6'h0E;
  localparam logic [5:0] TIMER0_FLAGS = 6'h15;
  localparam logic [5:0] TIMER1_FLAGS = 6'h16;
  localparam logic [5:0] TIMER2_FLAGS = 6'h17;
  localparam logic [5:0] EXTERNAL_IRQ_MASK = 6'h1D;
  localparam logic [5:0] SCRATCH_REG_0 = 6'h1E;
  localparam logic [5:0] EEPROM_CONTROL = 6'h20;
  localparam logic [5:0] EEPROM_ADDR_LOW = 6'h21;
  localparam logic [5:0] EEPROM_ADDR_HIGH = 6'h22;
  localparam logic [5:0] GENERAL_TIMER_CONTROL = 6'h23;
  localparam logic [5:0] TIMER0_CONTROL_A = 6'h24;
  localparam logic [5:0] TIMER0_CONTROL_B = 6'h25;
  localparam logic [5:0] TIMER0_COUNT = 6'h26;
  localparam logic [5:0] TIMER0_COMPARE_A = 6'h27;
  localparam logic [5:0] TIMER0_COMPARE_B = 6'h28;
  localparam logic [5:0] SCRATCH_REG_1 = 6'h2A;
  localparam logic [5:0] SCRATCH_REG_2 = 6'h2B;
  localparam logic [5:0] SERIAL_PERIPH_CONTROL = 6'h2C;
  localparam logic [5:0] SERIAL_PERIPH_STATUS = 6'h2D;
  localparam logic [5:0] SERIAL_PERIPH_BUFFER = 6'h2E;
  localparam logic [5:0] COMPARATOR_AUX_CONTROL = 6'h2F;
  localparam logic [5:0] COMPARATOR_CONTROL = 6'h31;
  localparam logic [5:0] SLEEP_CONTROL = 6'h33;
  localparam logic [5:0] RESET_CAUSE_FLAGS = 6'h34;
  localparam logic [5:0] CORE_CONTROL = 6'h35;
  localparam logic [5:0] SELF_PROGRAM_CONTROL = 6'h37;

  localparam logic [7:0] IO_RESET_VALUE = 8'h00;
  localparam int NUM_FLAG_REGS = 4;
  localparam logic [3:0][5:0] FLAG_REG_IDX = {COMPARATOR_CONTROL, TIMER2_FLAGS,
                                              TIMER1_FLAGS, TIMER0_FLAGS};

  // Bits that exist in each location; everything else is reserved
  function automatic logic [7:0] io_impl_mask(input logic [5:0] a);
    case (a)
      PORT_B_INPUT_PINS, PORT_B_DIRECTION, PORT_B_OUTPUT: io_impl_mask = 8'hFF;
      PORT_C_INPUT_PINS, PORT_C_DIRECTION, PORT_C_OUTPUT: io_impl_mask = 8'h7F;
      PORT_D_INPUT_PINS, PORT_D_DIRECTION, PORT_D_OUTPUT: io_impl_mask = 8'hFF;
      PORT_E_INPUT_PINS, PORT_E_DIRECTION, PORT_E_OUTPUT: io_impl_mask = 8'h0F;
      TIMER0_FLAGS, TIMER2_FLAGS: io_impl_mask = 8'h07;
      TIMER1_FLAGS: io_impl_mask = 8'h27;
      EXTERNAL_IRQ_MASK: io_impl_mask = 8'h03;
      EEPROM_CONTROL: io_impl_mask = 8'h3F;
      GENERAL_TIMER_CONTROL: io_impl_mask = 8'h83;
      TIMER0_CONTROL_A: io_impl_mask = 8'hF3;
      TIMER0_CONTROL_B: io_impl_mask = 8'hCF;
      SERIAL_PERIPH_STATUS: io_impl_mask = 8'hC1;
      COMPARATOR_AUX_CONTROL: io_impl_mask = 8'h01;
      SLEEP_CONTROL, RESET_CAUSE_FLAGS: io_impl_mask = 8'h0F;
      CORE_CONTROL: io_impl_mask = 8'h73;
      SCRATCH_REG_0, EEPROM_ADDR_LOW, EEPROM_ADDR_HIGH, TIMER0_COUNT,
      TIMER0_COMPARE_A, TIMER0_COMPARE_B, SCRATCH_REG_1, SCRATCH_REG_2,
      SERIAL_PERIPH_CONTROL, SERIAL_PERIPH_BUFFER, COMPARATOR_CONTROL,
      SELF_PROGRAM_CONTROL: io_impl_mask = 8'hFF;
      default: io_impl_mask = 8'h00;
    endcase
  endfunction : io_impl_mask

  // Flags that software clears by writing a one
  function automatic logic [7:0] io_w1c_mask(input logic [5:0] a);
    case (a)
      TIMER0_FLAGS, TIMER2_FLAGS: io_w1c_mask = 8'h07;
      TIMER1_FLAGS: io_w1c_mask = 8'h27;
      COMPARATOR_CONTROL: io_w1c_mask = 8'h10;
      default: io_w1c_mask = 8'h00;
    endcase
  endfunction : io_w1c_mask

  function automatic logic io_is_pin(input logic [5:0] a);
    io_is_pin = (a == PORT_B_INPUT_PINS) || (a == PORT_C_INPUT_PINS) ||
                (a == PORT_D_INPUT_PINS) || (a == PORT_E_INPUT_PINS);
  endfunction : io_is_pin

  localparam logic [5:0] PIN_TO_OUTPUT = 6'h02;

  localparam int AXI_AW = 4;
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h4;
  localparam logic [3:0] HREG_IRQ_STAT = 4'h8;
  localparam logic [3:0] HREG_IRQ_MASK = 4'hC;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_WDATA_LSB = 8;
  localparam int CMD_BIT_LSB = 16;
  localparam int CMD_OP_LSB = 20;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SKIP_BIT = 1;
  localparam int ST_ERR_BIT = 2;
  localparam int ST_RDATA_LSB = 8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage : iosd_pkg
`default_nettype wire

// ### logic/iosd_bus_if.sv
/*
  Core-side bus between the processor core end and the I/O decoder.
  Assumes one clock; req is a one-cycle pulse, ack answers it.
*/
`timescale 1ns/1ps
`default_nettype none
interface iosd_bus_if import iosd_pkg::*; ();
  logic req;
  iosd_op_e op;
  logic [7:0] addr;
  logic [2:0] bitn;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic skip;
  logic err;

  modport dev (input req, op, addr, bitn, wdata, output ack, rdata, skip, err);
  modport core (output req, op, addr, bitn, wdata, input ack, rdata, skip, err);
endinterface : iosd_bus_if
`default_nettype wire

// ### logic/iosd_dev_end.sv
/*
  I/O register space decoder: holds the 64-location I/O window, decodes
  port, data-space and single-bit operations, forwards the extended range.
  Assumes the core issues one request at a time and waits for ack.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Bit set/clear on I/O 0x00..0x1F
// - Skip tests any bit in 0x00..0x1F
// - Bit ops alter only the addressed bit; a set on a pin location also toggles that bit of the port output
// - Writing one clears flags, zero keeps
// - Port ops decode the 64-location window
// - Data ops see I/O at plus 0x20
// - Extended range only via data ops
// - Never write reserved addresses
// - Write zeros to reserved bits
module iosd_dev_end import iosd_pkg::*; (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  iosd_bus_if.dev BUS,
  input wire logic [7:0] PIN_B_IN,
  input wire logic [7:0] PIN_C_IN,
  input wire logic [7:0] PIN_D_IN,
  input wire logic [7:0] PIN_E_IN,
  input wire logic [NUM_FLAG_REGS-1:0][7:0] FLAG_EVT_IN,
  input wire logic EXT_ACK_IN,
  input wire logic [7:0] EXT_RDATA_IN,
  output logic [IO_SIZE-1:0][7:0] IO_REGS_OUT,
  output logic EXT_STB_OUT,
  output logic EXT_WE_OUT,
  output logic [7:0] EXT_ADDR_OUT,
  output logic [7:0] EXT_WDATA_OUT
);

  typedef struct packed {
    logic [IO_SIZE-1:0][7:0] io;
    logic pend;
    logic ack;
    logic [7:0] rdata;
    logic skip;
    logic err;
    logic ext_stb;
    logic ext_we;
    logic [7:0] ext_addr;
    logic [7:0] ext_wdata;
  } iosd_dev_s;

  iosd_dev_s q;
  iosd_dev_s d;

  logic port_op;
  logic data_op;
  logic bit_op;
  logic skip_op;
  logic hit;
  logic bad;
  logic ext;
  logic wr;
  logic [5:0] idx;
  logic [7:0] wmask;
  logic [7:0] wdat;
  logic [7:0] rd;
  logic [7:0] cur;
  logic [7:0] w1c;
  logic [7:0] bsel;
  logic [7:0] data_rel;

  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.skip = 1'b0;
    d.err = 1'b0;
    d.ext_stb = 1'b0;
    port_op = (BUS.op == OP_IO_PORT_READ) || (BUS.op == OP_IO_PORT_WRITE);
    data_op = (BUS.op == OP_DATA_FETCH) || (BUS.op == OP_DATA_WRITE);
    skip_op = (BUS.op == OP_SKIP_IF_BIT_SET) || (BUS.op == OP_SKIP_IF_BIT_CLEAR);
    bit_op = (BUS.op == OP_SET_IO_BIT) || (BUS.op == OP_CLEAR_IO_BIT) || skip_op;
    bsel = 8'h01 << BUS.bitn;
    data_rel = BUS.addr - DATA_IO_OFFSET;
    hit = 1'b0;
    bad = 1'b0;
    ext = 1'b0;
    idx = 6'h00;
    if (port_op) begin
      hit = (BUS.addr <= IO_LAST);
      idx = BUS.addr[5:0];
    end else if (bit_op) begin
      hit = (BUS.addr <= BIT_IO_LAST);
      idx = BUS.addr[5:0];
    end else if (data_op) begin
      // Below the window lies the core register file, not ours
      hit = (BUS.addr >= DATA_IO_OFFSET) && (BUS.addr <= DATA_IO_LAST);
      idx = data_rel[5:0];
      ext = (BUS.addr >= EXT_FIRST);
    end
    bad = !(hit || ext);
    wr = 1'b0;
    wmask = 8'h00;
    wdat = 8'h00;
    // Pin locations read the live pins, not the stored byte
    case (idx)
      PORT_B_INPUT_PINS: rd = PIN_B_IN & io_impl_mask(idx);
      PORT_C_INPUT_PINS: rd = PIN_C_IN & io_impl_mask(idx);
      PORT_D_INPUT_PINS: rd = PIN_D_IN & io_impl_mask(idx);
      PORT_E_INPUT_PINS: rd = PIN_E_IN & io_impl_mask(idx);
      default: rd = q.io[idx];
    endcase

    if (q.pend) begin
      // Extended access held open until the far side answers
      if (EXT_ACK_IN) begin
        d.pend = 1'b0;
        d.ack = 1'b1;
        d.rdata = q.ext_we ? 8'h00 : EXT_RDATA_IN;
      end
    end else if (BUS.req) begin
      if (ext) begin
        d.pend = 1'b1;
        d.ext_stb = 1'b1;
        d.ext_we = (BUS.op == OP_DATA_WRITE);
        d.ext_addr = BUS.addr;
        d.ext_wdata = BUS.wdata;
      end else begin
        d.ack = 1'b1;
        d.err = bad;
        d.rdata = 8'h00;
        if (!bad) begin
          case (BUS.op)
            OP_IO_PORT_READ, OP_DATA_FETCH: begin
              d.rdata = rd;
            end
            OP_IO_PORT_WRITE, OP_DATA_WRITE: begin
              wr = 1'b1;
              wmask = 8'hFF;
              wdat = BUS.wdata;
            end
            OP_SET_IO_BIT: begin
              wr = 1'b1;
              wmask = bsel;
              wdat = 8'hFF;
            end
            OP_CLEAR_IO_BIT: begin
              wr = 1'b1;
              wmask = bsel;
              wdat = 8'h00;
            end
            OP_SKIP_IF_BIT_SET: begin
              d.rdata = rd;
              d.skip = |(rd & bsel);
            end
            OP_SKIP_IF_BIT_CLEAR: begin
              d.rdata = rd;
              d.skip = !(|(rd & bsel));
            end
            default: begin
              d.err = 1'b1;
            end
          endcase
        end
      end
    end

    for (int i = 0; i < IO_SIZE; i++) begin
      cur = q.io[i];
      w1c = io_w1c_mask(6'(i));
      if (wr && (idx == 6'(i))) begin
        // Plain bits take the masked value; flags only ever clear
        cur = (((cur & ~wmask) | (wdat & wmask)) & ~w1c) |
              (cur & w1c & ~(wmask & wdat));
      end
      if (io_is_pin(6'(i))) begin
        cur = 8'h00;
      end
      d.io[i] = cur & io_impl_mask(6'(i));
    end

    // A one written to a pin location toggles the matching output bits
    if (wr && io_is_pin(idx)) begin
      d.io[idx + PIN_TO_OUTPUT] = d.io[idx + PIN_TO_OUTPUT] ^
                                   (wmask & wdat & io_impl_mask(idx));
    end

    // Events applied last so a set in the clearing cycle survives
    for (int f = 0; f < NUM_FLAG_REGS; f++) begin
      d.io[FLAG_REG_IDX[f]] = d.io[FLAG_REG_IDX[f]] |
                              (FLAG_EVT_IN[f] & io_w1c_mask(FLAG_REG_IDX[f]));
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      q <= '0;
      for (int i = 0; i < IO_SIZE; i++) begin
        q.io[i] <= IO_RESET_VALUE;
      end
    end else begin
      q <= d;
    end
  end

  assign BUS.ack = q.ack;
  assign BUS.rdata = q.rdata;
  assign BUS.skip = q.skip;
  assign BUS.err = q.err;
  assign IO_REGS_OUT = q.io;
  assign EXT_STB_OUT = q.ext_stb;
  assign EXT_WE_OUT = q.ext_we;
  assign EXT_ADDR_OUT = q.ext_addr;
  assign EXT_WDATA_OUT = q.ext_wdata;

endmodule : iosd_dev_end
`default_nettype wire

// ### logic/iosd_core_end.sv
/*
  Core-side end: takes commands from software over AXI4-Lite and issues
  them on the core bus, one at a time, reporting result and interrupts.
  Assumes the decoder answers every request with one ack.
*/
`timescale 1ns/1ps
`default_nettype none
module iosd_core_end import iosd_pkg::*; (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  iosd_bus_if.core BUS,
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic IRQ_OUT
);

  typedef struct packed {
    logic aw_have;
    logic [AXI_AW-1:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic busy;
    logic req;
    iosd_op_e op;
    logic [7:0] addr;
    logic [2:0] bitn;
    logic [7:0] wd;
    logic [7:0] result;
    logic skip;
    logic err;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
  } iosd_core_s;

  iosd_core_s q;
  iosd_core_s d;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  always_comb begin
    d = q;
    d.req = 1'b0;
    irq_set = 2'h0;
    irq_clr = 2'h0;
    if (S_AXI_AWVALID && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = S_AXI_WDATA;
      d.wstrb = S_AXI_WSTRB;
    end
    if (q.bvalid && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = AXI_OKAY;
      case (q.aw_addr)
        HREG_CMD: begin
          // A command while busy is dropped; software polls busy first
          if (!q.busy && (q.wstrb != 4'h0)) begin
            d.busy = 1'b1;
            d.req = 1'b1;
            d.addr = q.wdata[CMD_ADDR_LSB +: 8];
            d.wd = q.wdata[CMD_WDATA_LSB +: 8];
            d.bitn = q.wdata[CMD_BIT_LSB +: 3];
            d.op = iosd_op_e'(q.wdata[CMD_OP_LSB +: 4]);
          end
        end
        HREG_STATUS: begin
        end
        HREG_IRQ_STAT: begin
          if (q.wstrb[0]) begin
            irq_clr = q.wdata[1:0];
          end
        end
        HREG_IRQ_MASK: begin
          if (q.wstrb[0]) begin
            d.irq_mask = q.wdata[1:0];
          end
        end
        default: begin
          d.bresp = AXI_SLVERR;
        end
      endcase
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;

    if (q.rvalid && S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = AXI_OKAY;
      d.rdata = 32'h00000000;
      case (S_AXI_ARADDR)
        HREG_CMD: begin
          d.rdata[CMD_ADDR_LSB +: 8] = q.addr;
          d.rdata[CMD_WDATA_LSB +: 8] = q.wd;
          d.rdata[CMD_BIT_LSB +: 3] = q.bitn;
          d.rdata[CMD_OP_LSB +: 4] = q.op;
        end
        HREG_STATUS: begin
          d.rdata[ST_BUSY_BIT] = q.busy;
          d.rdata[ST_SKIP_BIT] = q.skip;
          d.rdata[ST_ERR_BIT] = q.err;
          d.rdata[ST_RDATA_LSB +: 8] = q.result;
        end
        HREG_IRQ_STAT: begin
          d.rdata[1:0] = q.irq_stat;
        end
        HREG_IRQ_MASK: begin
          d.rdata[1:0] = q.irq_mask;
        end
        default: begin
          d.rresp = AXI_SLVERR;
        end
      endcase
    end
    d.arready = !d.rvalid;

    if (q.busy && BUS.ack) begin
      d.busy = 1'b0;
      d.result = BUS.rdata;
      d.skip = BUS.skip;
      d.err = BUS.err;
      irq_set[IRQ_DONE_BIT] = 1'b1;
      irq_set[IRQ_ERR_BIT] = BUS.err;
    end
    // Set beats clear when both land in one cycle
    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign BUS.req = q.req;
  assign BUS.op = q.op;
  assign BUS.addr = q.addr;
  assign BUS.bitn = q.bitn;
  assign BUS.wdata = q.wd;
  assign S_AXI_AWREADY = q.awready;
  assign S_AXI_WREADY = q.wready;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_ARREADY = q.arready;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign S_AXI_RVALID = q.rvalid;
  assign IRQ_OUT = q.irq;

endmodule : iosd_core_end
`default_nettype wire

// ### bench/iosd_bus_properties.sv
/*
  Concurrent checks on the core bus between the two decoder ends.
  Assumes the extended space answers within a few cycles of its strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module iosd_bus_properties import iosd_pkg::*; (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic req,
  input wire iosd_op_e op,
  input wire logic [7:0] addr,
  input wire logic [2:0] bitn,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic skip,
  input wire logic err
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  wire logic port_op = op == OP_IO_PORT_READ || op == OP_IO_PORT_WRITE;
  wire logic bit_op = op == OP_SET_IO_BIT || op == OP_CLEAR_IO_BIT;
  wire logic skip_op = op == OP_SKIP_IF_BIT_SET || op == OP_SKIP_IF_BIT_CLEAR;
  wire logic data_op = op == OP_DATA_FETCH || op == OP_DATA_WRITE;
  wire logic ext = data_op && addr >= EXT_FIRST;

  AST_PORT_RANGE: assert property (req && port_op |=> ack && err == ($past(addr) > IO_LAST))
    else $error("port op window decode wrong");
  AST_BIT_RANGE: assert property (req && bit_op |=> ack && err == ($past(addr) > BIT_IO_LAST))
    else $error("bit op window decode wrong");
  AST_SKIP_RANGE: assert property (req && skip_op |=> ack && err == ($past(addr) > BIT_IO_LAST))
    else $error("skip op window decode wrong");
  AST_DATA_MAP: assert property (req && data_op && !ext |=> ack
    && err == ($past(addr) < DATA_IO_OFFSET))
    else $error("data op window decode wrong");
  AST_EXT_WAIT: assert property (req && ext |=> !ack)
    else $error("extended access answered too early");
  AST_EXT_DONE: assert property (req && ext |-> ##[2:8] (ack && !err))
    else $error("extended access not completed");
  AST_QUIET: assert property (!ack |-> !skip && !err)
    else $error("skip or err outside ack");
  AST_RDATA_STANDS: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");

  COV_BIT: cover property (req && bit_op ##1 ack);
  COV_SKIP: cover property (req && skip_op ##1 skip);
  COV_EXT: cover property (req && ext);
endmodule : iosd_bus_properties
`default_nettype wire

// ### bench/io_space_register_decoder_test.sv
/*
  Bench for the I/O space decoder: both ends joined, commands sent over AXI4-Lite.
  Assumes a simple extended space that answers one cycle after each strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module io_space_register_decoder_test import iosd_pkg::*; ();
  logic CLK_IN = 1'b0;
  logic SYS_RST_IN = 1'b1;
  int miscompares = 0;
  int comparisons = 0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, ext_stb, ext_we;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, st;
  logic [7:0] pins = 8'h3C;
  logic [NUM_FLAG_REGS-1:0][7:0] evt = '0;
  logic ext_ack = 1'b0;
  logic [7:0] ext_rd = 8'h00, ext_addr, ext_wd;
  logic [IO_SIZE-1:0][7:0] io;
  always #50 CLK_IN = ~CLK_IN;

  iosd_bus_if i_iosd_bus_if ();
  iosd_dev_end i_iosd_dev_end (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .BUS(i_iosd_bus_if),
    .PIN_B_IN(pins), .PIN_C_IN(pins), .PIN_D_IN(pins), .PIN_E_IN(pins), .FLAG_EVT_IN(evt),
    .EXT_ACK_IN(ext_ack), .EXT_RDATA_IN(ext_rd), .IO_REGS_OUT(io), .EXT_STB_OUT(ext_stb),
    .EXT_WE_OUT(ext_we), .EXT_ADDR_OUT(ext_addr), .EXT_WDATA_OUT(ext_wd));
  iosd_core_end i_iosd_core_end (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .BUS(i_iosd_bus_if),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IRQ_OUT(irq));
  iosd_bus_properties i_iosd_bus_properties (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .req(i_iosd_bus_if.req), .op(i_iosd_bus_if.op), .addr(i_iosd_bus_if.addr),
    .bitn(i_iosd_bus_if.bitn), .wdata(i_iosd_bus_if.wdata), .ack(i_iosd_bus_if.ack),
    .rdata(i_iosd_bus_if.rdata), .skip(i_iosd_bus_if.skip), .err(i_iosd_bus_if.err));

  // Extended space: data is a scramble of the address so a stale byte shows
  always @(posedge CLK_IN) begin
    ext_ack <= ext_stb;
    ext_rd <= ext_addr ^ 8'hA5;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Each AXI task opens on a fresh edge so no strobe is assigned twice in one step
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_IN);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge CLK_IN);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a);
    @(posedge CLK_IN);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge CLK_IN);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    st = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic run(input iosd_op_e o, input logic [7:0] a, input logic [7:0] d,
                     input logic [2:0] b);
    axi_wr(HREG_CMD, {8'h00, o, 1'b0, b, d, a});
    do axi_rd(HREG_STATUS); while (st[ST_BUSY_BIT] !== 1'b0);
  endtask : run

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  initial begin
    #(100 * 20000);
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge CLK_IN);
    SYS_RST_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
    chk("irq", 8'h00, {7'h0, irq});
    chk("flags", IO_RESET_VALUE, io[TIMER0_FLAGS]);
    axi_rd(4'h2);
    chk("resp", {6'h0, AXI_SLVERR}, {6'h0, resp});
    chk("unmapped", 8'h00, st[7:0]);
    done("reset");
    run(OP_IO_PORT_WRITE, {2'b00, SCRATCH_REG_1}, 8'h5A, 3'h0);
    run(OP_DATA_FETCH, {2'b00, SCRATCH_REG_1} + 8'h20, 8'h00, 3'h0);
    chk("rdata", 8'h5A, st[15:8]);
    run(OP_IO_PORT_READ, {2'b00, PORT_B_INPUT_PINS}, 8'h00, 3'h0);
    chk("pins", 8'h3C, st[15:8]);
    // A one written to a pin location toggles the output byte
    run(OP_IO_PORT_WRITE, {2'b00, PORT_B_INPUT_PINS}, 8'h0F, 3'h0);
    chk("toggle", 8'h0F, io[PORT_B_OUTPUT]);
    run(OP_IO_PORT_WRITE, 8'h40, 8'h11, 3'h0);
    chk("err", 8'h01, {7'h0, st[ST_ERR_BIT]});
    run(OP_DATA_FETCH, 8'h10, 8'h00, 3'h0);
    chk("err", 8'h01, {7'h0, st[ST_ERR_BIT]});
    run(OP_IO_PORT_WRITE, {2'b00, EXTERNAL_IRQ_MASK}, 8'hFF, 3'h0);
    chk("mask bits", 8'h03, io[EXTERNAL_IRQ_MASK]);
    run(OP_IO_PORT_READ, 8'h3C, 8'h00, 3'h0);
    chk("reserved", 8'h00, st[15:8]);
    done("windows");
    evt[0] <= 8'hFF;
    @(posedge CLK_IN);
    evt[0] <= 8'h00;
    @(posedge CLK_IN);
    chk("flags", 8'h07, io[TIMER0_FLAGS]);
    run(OP_SET_IO_BIT, {2'b00, TIMER0_FLAGS}, 8'h00, 3'h1);
    chk("flags", 8'h05, io[TIMER0_FLAGS]);
    run(OP_IO_PORT_WRITE, {2'b00, TIMER0_FLAGS}, 8'h00, 3'h0);
    chk("flags", 8'h05, io[TIMER0_FLAGS]);
    run(OP_IO_PORT_WRITE, {2'b00, TIMER0_FLAGS}, 8'h01, 3'h0);
    chk("flags", 8'h04, io[TIMER0_FLAGS]);
    done("flags");
    run(OP_IO_PORT_WRITE, {2'b00, PORT_B_DIRECTION}, 8'hF0, 3'h0);
    run(OP_CLEAR_IO_BIT, {2'b00, PORT_B_DIRECTION}, 8'h00, 3'h4);
    chk("dir", 8'hE0, io[PORT_B_DIRECTION]);
    run(OP_SET_IO_BIT, {2'b00, PORT_B_DIRECTION}, 8'h00, 3'h0);
    chk("dir", 8'hE1, io[PORT_B_DIRECTION]);
    for (int i = 0; i < 8; i++) begin
      run(OP_SKIP_IF_BIT_SET, {2'b00, PORT_B_DIRECTION}, 8'h00, i[2:0]);
      chk("skip", (8'hE1 >> i) & 8'h01, {7'h0, st[ST_SKIP_BIT]});
      run(OP_SKIP_IF_BIT_CLEAR, {2'b00, PORT_B_DIRECTION}, 8'h00, i[2:0]);
      chk("skip", ~(8'hE1 >> i) & 8'h01, {7'h0, st[ST_SKIP_BIT]});
    end
    // The top of the bit window is reserved, so it is only ever tested, not written
    run(OP_SET_IO_BIT, {2'b00, SCRATCH_REG_0}, 8'h00, 3'h7);
    chk("err", 8'h00, {7'h0, st[ST_ERR_BIT]});
    chk("scratch", 8'h80, io[SCRATCH_REG_0]);
    run(OP_SKIP_IF_BIT_SET, BIT_IO_LAST, 8'h00, 3'h0);
    chk("err", 8'h00, {7'h0, st[ST_ERR_BIT]});
    run(OP_SET_IO_BIT, 8'h20, 8'h00, 3'h0);
    chk("err", 8'h01, {7'h0, st[ST_ERR_BIT]});
    run(OP_SKIP_IF_BIT_CLEAR, 8'h20, 8'h00, 3'h0);
    chk("err", 8'h01, {7'h0, st[ST_ERR_BIT]});
    done("bit ops");
    run(OP_DATA_WRITE, EXT_FIRST, 8'h33, 3'h0);
    chk("err", 8'h00, {7'h0, st[ST_ERR_BIT]});
    chk("ext addr", 8'h60, ext_addr);
    chk("ext data", 8'h33, ext_wd);
    chk("ext we", 8'h01, {7'h0, ext_we});
    run(OP_DATA_FETCH, 8'hFF, 8'h00, 3'h0);
    chk("ext rdata", 8'h5A, st[15:8]);
    run(OP_IO_PORT_WRITE, EXT_FIRST, 8'h33, 3'h0);
    chk("err", 8'h01, {7'h0, st[ST_ERR_BIT]});
    done("extended");
    chk("irq", 8'h00, {7'h0, irq});
    axi_wr(HREG_IRQ_MASK, 32'h1);
    chk("bresp", {6'h0, AXI_OKAY}, {6'h0, resp});
    repeat (2) @(posedge CLK_IN);
    chk("irq", 8'h01, {7'h0, irq});
    axi_wr(HREG_IRQ_STAT, 32'h3);
    repeat (2) @(posedge CLK_IN);
    chk("irq", 8'h00, {7'h0, irq});
    axi_rd(HREG_IRQ_STAT);
    chk("irq stat", 8'h00, st[7:0]);
    done("interrupt");
    complete_run();
  end
endmodule : io_space_register_decoder_test
`default_nettype wire
